// >>> hw/bfcce_unit.sv
// decode and execute unit for bit-field invert, zero and signed extract
`timescale 1ns/1ps
module bfcce_unit
  import bfcce_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // instruction words from fetch, same clock
  input  wire logic         start,
  input  wire logic [15:0]  opWord,
  input  wire logic [15:0]  extWord,
  input  wire logic [31:0]  eaAddr,
  // data registers from the core
  input  wire bfcce_dregs_t dataRegs,
  // operand memory
  output bfcce_mem_t        mem,
  input  wire logic         memAck,
  input  wire logic [39:0]  memRData,
  // results
  output logic              busy,
  output logic              done,
  output logic              illegal,
  output bfcce_cc_t         cc,
  output logic              regWe,
  output logic [2:0]        regIdx,
  output logic [31:0]       regData
);

  bfcce_regs_t s_q;
  bfcce_regs_t s_d;

  logic        fMsb;
  logic        fZero;
  logic [31:0] fSext;
  logic [31:0] fNewReg;
  logic [39:0] fNewWin;
  logic        isRegOp;
  logic [4:0]  fStart;
  logic [39:0] fWin;

  // register operand rotates the whole word; memory uses the bit within the first byte
  assign isRegOp = s_q.eaMode == BFCCE_EA_DREG;
  assign fStart  = isRegOp ? s_q.offset[4:0] : {2'h0, s_q.offset[2:0]};
  assign fWin    = isRegOp ? {dataRegs[s_q.eaReg], 8'h00} : s_q.win;

  bfcce_field u_field (
    .win       (fWin),
    .isReg     (isRegOp),
    .start     (fStart),
    .width     (s_q.width),
    .invert    (s_q.op == FIELD_INVERT_OP),
    .fieldMsb  (fMsb),
    .fieldZero (fZero),
    .sextVal   (fSext),
    .newReg    (fNewReg),
    .newWin    (fNewWin)
  );

  // legal base location for all three ops
  function automatic logic baseOk(input logic [2:0] mode, input logic [2:0] rg);
    case (mode)
      BFCCE_EA_DREG, BFCCE_EA_IND, BFCCE_EA_DISP, BFCCE_EA_IDX: baseOk = 1'b1;
      BFCCE_EA_EXT: baseOk = (rg == BFCCE_EXT_ABSW) || (rg == BFCCE_EXT_ABSL);
      default:      baseOk = 1'b0;
    endcase
  endfunction

  // next-state logic
  always_comb
  begin
    logic        opOk;
    logic        extOk;
    logic [2:0]  nBytes;
    logic [5:0]  span;
    logic [31:0] wsrc;
    s_d        = s_q;
    opOk       = 1'b0;
    extOk      = 1'b1;
    nBytes     = 3'h0;
    span       = 6'h0;
    wsrc       = 32'h0;
    s_d.done   = 1'b0;
    s_d.regWe  = 1'b0;
    case (s_q.st)
      BFCCE_IDLE:
      begin
        if (start)
        begin
          opOk = 1'b1;
          case (opWord[15:6])
            BFCCE_OPC_INVERT: s_d.op = FIELD_INVERT_OP;
            BFCCE_OPC_ZERO:   s_d.op = FIELD_ZERO_OP;
            BFCCE_OPC_SEXT:   s_d.op = FIELD_SIGNED_EXTRACT_OP;
            default:          opOk   = 1'b0;
          endcase
          s_d.ext     = extWord;
          s_d.eaMode  = opWord[5:3];
          s_d.eaReg   = opWord[2:0];
          s_d.ea      = eaAddr;
          s_d.busy    = 1'b1;
          s_d.illegal = ~opOk;
          s_d.cc      = '0;
          s_d.st      = opOk ? BFCCE_DECODE : BFCCE_FINISH;
          s_d.done    = 1'b0;
        end
      end
      BFCCE_DECODE:
      begin
        if (s_q.ext[15])
          extOk = 1'b0;
        if (s_q.op != FIELD_SIGNED_EXTRACT_OP && s_q.ext[BFCCE_X_DST_HI:BFCCE_X_DST_LO] != 3'h0)
          extOk = 1'b0;
        // register offset: bits 10-9 zero; full signed value
        if (s_q.ext[BFCCE_X_DO])
        begin
          if (s_q.ext[BFCCE_X_OFF_HI:BFCCE_X_OREG_HI+1] != 2'h0)
            extOk = 1'b0;
          s_d.offset = dataRegs[s_q.ext[BFCCE_X_OREG_HI:BFCCE_X_OFF_LO]];
        end
        else
          s_d.offset = {27'h0, s_q.ext[BFCCE_X_OFF_HI:BFCCE_X_OFF_LO]};
        // register width: bits 4-3 zero; modulo 32
        if (s_q.ext[BFCCE_X_DW])
        begin
          if (s_q.ext[BFCCE_X_WID_HI:BFCCE_X_WREG_HI+1] != 2'h0)
            extOk = 1'b0;
          wsrc = dataRegs[s_q.ext[BFCCE_X_WREG_HI:0]];
        end
        else
          wsrc = {27'h0, s_q.ext[BFCCE_X_WID_HI:0]};
        // zero code means a full 32-bit field
        s_d.width = (wsrc[4:0] == 5'h0) ? BFCCE_WIDTH_FULL : {1'b0, wsrc[4:0]};
        if (!baseOk(s_q.eaMode, s_q.eaReg) || !extOk)
        begin
          s_d.illegal = 1'b1;
          s_d.st      = BFCCE_FINISH;
        end
        else if (s_q.eaMode == BFCCE_EA_DREG)
          s_d.st = BFCCE_FINISH;
        else
        begin
          // only the bytes that hold part of the field
          span          = {3'h0, s_d.offset[2:0]} + s_d.width + 6'h07;
          nBytes        = span[5:3];
          s_d.mem.req   = 1'b1;
          s_d.mem.wr    = 1'b0;
          s_d.mem.addr  = s_q.ea + 32'($signed(s_d.offset) >>> 3);
          s_d.mem.bytes = nBytes;
          s_d.st        = BFCCE_MEMRD;
        end
      end
      BFCCE_MEMRD:
      begin
        if (memAck)
        begin
          s_d.mem.req = 1'b0;
          s_d.win     = memRData;
          s_d.st      = BFCCE_FINISH;
        end
      end
      BFCCE_MEMWR:
      begin
        if (memAck)
        begin
          s_d.mem.req = 1'b0;
          s_d.mem.wr  = 1'b0;
          s_d.done    = 1'b1;
          s_d.busy    = 1'b0;
          s_d.st      = BFCCE_IDLE;
        end
      end
      BFCCE_FINISH:
      begin
        if (s_q.illegal)
        begin
          s_d.done = 1'b1;
          s_d.busy = 1'b0;
          s_d.st   = BFCCE_IDLE;
        end
        else
        begin
          // flags from the field as read
          s_d.cc = '{valid: 1'b1, n: fMsb, z: fZero, v: 1'b0, c: 1'b0};
          if (s_q.op == FIELD_SIGNED_EXTRACT_OP)
          begin
            s_d.regWe   = 1'b1;
            s_d.regIdx  = s_q.ext[BFCCE_X_DST_HI:BFCCE_X_DST_LO];
            s_d.regData = fSext;
            s_d.done    = 1'b1;
            s_d.busy    = 1'b0;
            s_d.st      = BFCCE_IDLE;
          end
          else if (isRegOp)
          begin
            // modified field back into the base register
            s_d.regWe   = 1'b1;
            s_d.regIdx  = s_q.eaReg;
            s_d.regData = fNewReg;
            s_d.done    = 1'b1;
            s_d.busy    = 1'b0;
            s_d.st      = BFCCE_IDLE;
          end
          else
          begin
            // write back the same bytes that were read
            s_d.mem.req   = 1'b1;
            s_d.mem.wr    = 1'b1;
            s_d.mem.wdata = fNewWin;
            s_d.st        = BFCCE_MEMWR;
          end
        end
      end
      default:
      begin
        s_d = BFCCE_RESET;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s_q <= BFCCE_RESET;
    else
      s_q <= s_d;
  end

  // outputs straight from the state flops
  assign mem     = s_q.mem;
  assign busy    = s_q.busy;
  assign done    = s_q.done;
  assign illegal = s_q.illegal;
  assign cc      = s_q.cc;
  assign regWe   = s_q.regWe;
  assign regIdx  = s_q.regIdx;
  assign regData = s_q.regData;

  // postincrement base is refused at decode
  a_bad_mode: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == BFCCE_DECODE && s_q.eaMode == 3'h3) |=> ##1 (done && illegal))
    else $error("illegal base mode not refused");

  // data register base never reaches memory
  a_dreg_nomem: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == BFCCE_DECODE && s_q.eaMode == BFCCE_EA_DREG) |=> !mem.req)
    else $error("register base issued memory access");

  a_width_full: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == BFCCE_DECODE && !s_q.ext[5] && s_q.ext[4:0] == 5'h0) |=> s_q.width == 6'h20)
    else $error("zero width code not 32");

  // byte count stays within one to five
  a_mem_bytes: assert property (@(posedge clk) disable iff (reset)
    mem.req |-> (mem.bytes >= 3'h1 && mem.bytes <= BFCCE_MAX_BYTES))
    else $error("memory byte count out of range");

  a_req_hold: assert property (@(posedge clk) disable iff (reset)
    (mem.req && !memAck) |=> (mem.req && $stable(mem.addr) && $stable(mem.wr)))
    else $error("memory request dropped early");

  a_sext_nowrite: assert property (@(posedge clk) disable iff (reset)
    (s_q.op == FIELD_SIGNED_EXTRACT_OP) |-> !(mem.req && mem.wr))
    else $error("extract wrote memory");

  a_neg_flag: assert property (@(posedge clk) disable iff (reset)
    (done && regWe && s_q.op == FIELD_SIGNED_EXTRACT_OP) |-> cc.n == regData[31])
    else $error("negative flag differs from field sign");

  a_zero_flag: assert property (@(posedge clk) disable iff (reset)
    (done && regWe && s_q.op == FIELD_SIGNED_EXTRACT_OP) |-> cc.z == (regData == 32'h0))
    else $error("zero flag differs from field value");

  // overflow and carry cleared on every completion
  a_vc_clear: assert property (@(posedge clk) disable iff (reset)
    (done && !illegal) |-> (cc.valid && !cc.v && !cc.c))
    else $error("overflow or carry left set");

  // full-width zeroed register field writes back all zeros
  a_zero_reg: assert property (@(posedge clk) disable iff (reset)
    (done && regWe && s_q.op == FIELD_ZERO_OP && s_q.width == 6'h20) |-> regData == 32'h0)
    else $error("full-width zero left bits set");

endmodule // bfcce_unit

// >>> hw/bfcce_pkg.sv
// constants, types and state layout for the bit-field change/clear/extract unit
package bfcce_pkg;

  // opcode word bits 15..6
  localparam logic [9:0] BFCCE_OPC_INVERT  = 10'h3AB;
  localparam logic [9:0] BFCCE_OPC_ZERO    = 10'h3B3;
  localparam logic [9:0] BFCCE_OPC_SEXT    = 10'h3AF;

  // base-location mode codes and register codes under mode 111
  localparam logic [2:0] BFCCE_EA_DREG     = 3'h0;
  localparam logic [2:0] BFCCE_EA_IND      = 3'h2;
  localparam logic [2:0] BFCCE_EA_DISP     = 3'h5;
  localparam logic [2:0] BFCCE_EA_IDX      = 3'h6;
  localparam logic [2:0] BFCCE_EA_EXT      = 3'h7;
  localparam logic [2:0] BFCCE_EXT_ABSW    = 3'h0;
  localparam logic [2:0] BFCCE_EXT_ABSL    = 3'h1;

  // extension word field positions
  localparam int BFCCE_X_DST_HI  = 14;
  localparam int BFCCE_X_DST_LO  = 12;
  localparam int BFCCE_X_DO      = 11;
  localparam int BFCCE_X_OFF_HI  = 10;
  localparam int BFCCE_X_OFF_LO  = 6;
  localparam int BFCCE_X_OREG_HI = 8;
  localparam int BFCCE_X_DW      = 5;
  localparam int BFCCE_X_WID_HI  = 4;
  localparam int BFCCE_X_WREG_HI = 2;

  // field width that a zero width code stands for
  localparam logic [5:0] BFCCE_WIDTH_FULL  = 6'h20;
  // most bytes one memory field can touch
  localparam logic [2:0] BFCCE_MAX_BYTES   = 3'h5;

  typedef enum logic [2:0] {
    BFCCE_IDLE   = 3'h0,
    BFCCE_DECODE = 3'h1,
    BFCCE_MEMRD  = 3'h3,
    BFCCE_MEMWR  = 3'h2,
    BFCCE_FINISH = 3'h6
  } bfcce_state_t;

  typedef enum logic [1:0] {
    FIELD_INVERT_OP         = 2'h0,
    FIELD_ZERO_OP           = 2'h1,
    FIELD_SIGNED_EXTRACT_OP = 2'h2
  } bfcce_op_t;

  // eight data registers as seen from the core
  typedef logic [7:0][31:0] bfcce_dregs_t;

  // operand memory request; first byte sits in bits 39..32
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [2:0]  bytes;
    logic [39:0] wdata;
  } bfcce_mem_t;

  typedef struct packed {
    logic valid;
    logic n;
    logic z;
    logic v;
    logic c;
  } bfcce_cc_t;

  // whole state of the unit
  typedef struct packed {
    bfcce_state_t st;
    bfcce_op_t    op;
    logic [15:0]  ext;
    logic [2:0]   eaMode;
    logic [2:0]   eaReg;
    logic [31:0]  ea;
    logic [31:0]  offset;
    logic [5:0]   width;
    logic [39:0]  win;
    bfcce_mem_t   mem;
    bfcce_cc_t    cc;
    logic         busy;
    logic         done;
    logic         illegal;
    logic         regWe;
    logic [2:0]   regIdx;
    logic [31:0]  regData;
  } bfcce_regs_t;

  localparam bfcce_regs_t BFCCE_RESET = '0;

endpackage

// >>> hw/bfcce_field.sv
// field select, flag and modify datapath, shared by register and memory operands
`timescale 1ns/1ps
module bfcce_field
  import bfcce_pkg::*;
(
  // operand and field position
  input  wire logic [39:0] win,
  input  wire logic        isReg,
  input  wire logic [4:0]  start,
  input  wire logic [5:0]  width,
  input  wire logic        invert,
  // results
  output logic             fieldMsb,
  output logic             fieldZero,
  output logic [31:0]      sextVal,
  output logic [31:0]      newReg,
  output logic [39:0]      newWin
);

  logic [31:0] topMask;
  logic [31:0] aligned;
  logic [31:0] modAligned;
  logic [39:0] winMask;
  logic [5:0]  backShift;

  // field brought to the top; a register field wraps, so it is rotated
  always_comb
  begin
    topMask    = 32'hFFFFFFFF << (6'h20 - width);
    backShift  = 6'h20 - {1'b0, start};
    if (isReg)
      aligned  = (win[39:8] << start) | (win[39:8] >> backShift);
    else
      aligned  = 32'(win << start >> 8);
    fieldMsb   = aligned[31];
    fieldZero  = (aligned & topMask) == 32'h0;
    // arithmetic shift drags the field's top bit down as the sign
    sextVal    = 32'($signed(aligned & topMask) >>> (6'h20 - width));
    modAligned = invert ? (aligned ^ topMask) : (aligned & ~topMask);
    newReg     = (modAligned >> start) | (modAligned << backShift);
    winMask    = {topMask, 8'h00} >> start;
    newWin     = invert ? (win ^ winMask) : (win & ~winMask);
  end

endmodule // bfcce_field

// >>> testbench/bfcce_mem_model.sv
// operand memory model that answers the unit's byte-window requests
`timescale 1ns/1ps
module bfcce_mem_model
  import bfcce_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // request side
  input  wire bfcce_mem_t  mem,
  input  wire logic [3:0]  waitCycles,
  output logic             memAck,
  output logic [39:0]      memRData
);
  logic [7:0]  bytesArr [16];
  bfcce_mem_t  lastRd;
  bfcce_mem_t  lastWr;
  logic [3:0]  cnt;
  int          wrCount;

  // answer after waitCycles; idle data and bytes past the count carry junk,
  // so a unit that samples outside the ack edge or past its bytes is caught
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      memAck   <= 1'b0;
      memRData <= 40'h5A5A5A5A5A;
      cnt      <= 4'h0;
      wrCount  <= 0;
      // preload here so the array has a single writing process
      for (int i = 0; i < 16; i++)
        bytesArr[i] <= 8'h96 ^ 8'(i * 29);
    end
    else
    begin
      memAck   <= 1'b0;
      memRData <= ~memRData;
      if (mem.req && !memAck)
      begin
        if (cnt != waitCycles)
          cnt <= cnt + 4'h1;
        else
        begin
          cnt    <= 4'h0;
          memAck <= 1'b1;
          if (mem.wr)
          begin
            lastWr  <= mem;
            wrCount <= wrCount + 1;
            for (int i = 0; i < 5; i++)
              if (i < mem.bytes)
                bytesArr[4'(mem.addr + i)] <= mem.wdata[39 - 8 * i -: 8];
          end
          else
          begin
            lastRd <= mem;
            for (int i = 0; i < 5; i++)
              memRData[39 - 8 * i -: 8] <= (i < mem.bytes) ? bytesArr[4'(mem.addr + i)]
                                                           : ~bytesArr[4'(mem.addr + i)];
          end
        end
      end
    end
  end
endmodule // bfcce_mem_model

// >>> testbench/tb_top.sv
// self-checking bench for the bit-field invert, zero and signed-extract unit
`timescale 1ns/1ps
module tb_top
  import bfcce_pkg::*;
;
  logic         clk;
  logic         reset;
  logic         start;
  logic [15:0]  opWord;
  logic [15:0]  extWord;
  logic [31:0]  eaAddr;
  bfcce_dregs_t dataRegs;
  bfcce_mem_t   mem;
  logic         memAck;
  logic [39:0]  memRData;
  logic         busy;
  logic         done;
  logic         illegal;
  bfcce_cc_t    cc;
  logic         regWe;
  logic [2:0]   regIdx;
  logic [31:0]  regData;
  logic [3:0]   waitCycles;
  logic [7:0]   memImg [16];
  int           errCount;
  int           checkCount;
  // memory cases: ops, base modes, extension words, offsets, widths
  logic [9:0]   opTab  [3] = '{BFCCE_OPC_INVERT, BFCCE_OPC_ZERO, BFCCE_OPC_SEXT};
  logic [5:0]   eaTab  [5] = '{6'h11, 6'h2B, 6'h34, 6'h38, 6'h39};
  logic [15:0]  extTab [5] = '{16'h00C5, 16'h0308, 16'h58D4, 16'h01D9, 16'h0140};
  logic [31:0]  offTab [5] = '{32'h3, 32'hC, 32'hFFFFFFF3, 32'h7, 32'h5};
  int           wTab   [5] = '{5, 8, 20, 25, 32};
  // refused cases: bad base modes, unknown opcode, nonzero reserved bits
  logic [9:0]   badOpc [9] = '{BFCCE_OPC_INVERT, BFCCE_OPC_ZERO, BFCCE_OPC_INVERT,
                              BFCCE_OPC_ZERO, BFCCE_OPC_INVERT, 10'h3AA, BFCCE_OPC_SEXT,
                              BFCCE_OPC_INVERT, BFCCE_OPC_ZERO};
  logic [5:0]   badEa  [9] = '{6'h08, 6'h19, 6'h22, 6'h3C, 6'h3A, 6'h00, 6'h01, 6'h01, 6'h01};
  logic [15:0]  badExt [9] = '{16'h0101, 16'h0101, 16'h0101, 16'h0101, 16'h0101, 16'h0101,
                              16'h0A41, 16'h0029, 16'h1101};

  bfcce_unit bfcce_unit_inst (.clk(clk), .reset(reset), .start(start), .opWord(opWord),
    .extWord(extWord), .eaAddr(eaAddr), .dataRegs(dataRegs), .mem(mem), .memAck(memAck),
    .memRData(memRData), .busy(busy), .done(done), .illegal(illegal), .cc(cc),
    .regWe(regWe), .regIdx(regIdx), .regData(regData));

  bfcce_mem_model bfcce_mem_model_inst (.clk(clk), .reset(reset), .mem(mem),
    .waitCycles(waitCycles), .memAck(memAck), .memRData(memRData));

  // 125 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checkCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task finishTest;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one instruction: start pulse, then wait for done, sampling at the falling edge
  task run(input logic [9:0] opc, input logic [5:0] ea6, input logic [15:0] ext,
           input logic [31:0] ea);
    int n;
    n = 0;
    @(posedge clk);
    start   <= 1'b1;
    opWord  <= {opc, ea6};
    extWord <= ext;
    eaAddr  <= ea;
    @(posedge clk);
    start   <= 1'b0;
    do
    begin
      @(negedge clk);
      n++;
      // busy must rise on the edge that takes the start pulse
      if (n == 1)
        chk(40'(busy), 40'h1, "busy while working");
    end
    while (done !== 1'b1 && n < 300);
    chk(40'(done), 40'h1, "completion");
    chk(40'(busy), 40'h0, "busy at completion");
  endtask

  // flags, and for extract the destination write; rot holds the field at bit 31
  task chkFlags(input logic [9:0] opc, input logic [31:0] rot, input logic [31:0] mh,
                input int w, input logic [2:0] dst);
    chk(40'(cc), 40'({1'b1, rot[31], (rot & mh) == 32'h0, 2'b00}), "flags");
    chk(40'(illegal), 40'h0, "refusal");
    if (opc == BFCCE_OPC_SEXT)
    begin
      chk(40'(regWe), 40'h1, "extract write");
      chk(40'(regIdx), 40'(dst), "extract index");
      chk(40'(regData), {8'h00, $signed(rot & mh) >>> (32 - w)}, "extract value");
    end
  endtask

  // data register base; offset 0 is bit 31 and the field wraps past bit 0
  task regOp(input logic [9:0] opc, input logic [2:0] r, input logic [15:0] ext,
             input logic [31:0] off, input int w);
    logic [31:0] v;
    logic [31:0] rot;
    logic [31:0] mh;
    logic [31:0] m;
    v   = dataRegs[r];
    rot = (v << off[4:0]) | (v >> (32 - off[4:0]));
    mh  = 32'hFFFFFFFF << (32 - w);
    m   = (mh >> off[4:0]) | (mh << (32 - off[4:0]));
    run(opc, {3'h0, r}, ext, 32'h0);
    chkFlags(opc, rot, mh, w, ext[14:12]);
    if (opc != BFCCE_OPC_SEXT)
    begin
      chk(40'(regWe), 40'h1, "register write");
      chk(40'(regIdx), 40'(r), "write index");
      chk(40'(regData), 40'(opc == BFCCE_OPC_INVERT ? v ^ m : v & ~m), "field");
    end
  endtask

  // memory base; big-endian bytes, only the bytes that hold the field
  task memOp(input logic [9:0] opc, input logic [5:0] ea6, input logic [15:0] ext,
             input logic [31:0] off, input int w);
    logic [31:0] a;
    logic [31:0] rot;
    logic [31:0] mh;
    logic [39:0] win;
    logic [39:0] t;
    logic [39:0] m40;
    logic [39:0] nw;
    logic [39:0] bm;
    int          nb;
    // cast keeps the shift arithmetic; an unsigned sum would turn it logical
    a = 32'h104 + 32'($signed(off) >>> 3);
    for (int k = 0; k < 5; k++)
      win[39 - 8 * k -: 8] = memImg[4'(a + k)];
    t   = win << off[2:0];
    rot = t[39:8];
    mh  = 32'hFFFFFFFF << (32 - w);
    m40 = {mh, 8'h00} >> off[2:0];
    nw  = (opc == BFCCE_OPC_INVERT) ? win ^ m40 : win & ~m40;
    nb  = (off[2:0] + w + 7) / 8;
    bm  = 40'hFFFFFFFFFF << (40 - 8 * nb);
    run(opc, ea6, ext, 32'h104);
    chk(40'(bfcce_mem_model_inst.lastRd.addr), 40'(a), "read address");
    chk(40'(bfcce_mem_model_inst.lastRd.bytes), 40'(nb), "read bytes");
    chkFlags(opc, rot, mh, w, ext[14:12]);
    if (opc != BFCCE_OPC_SEXT)
    begin
      chk(40'(regWe), 40'h0, "no register write");
      chk(40'(bfcce_mem_model_inst.lastWr.addr), 40'(a), "write address");
      chk(40'(bfcce_mem_model_inst.lastWr.bytes), 40'(nb), "write bytes");
      chk(bfcce_mem_model_inst.lastWr.wdata & bm, nw & bm, "written field");
      for (int k = 0; k < nb; k++)
        memImg[4'(a + k)] = nw[39 - 8 * k -: 8];
    end
  endtask

  // refused encodings finish with the refusal flag and touch nothing
  task badOp(input logic [9:0] opc, input logic [5:0] ea6, input logic [15:0] ext);
    int wc;
    wc = bfcce_mem_model_inst.wrCount;
    run(opc, ea6, ext, 32'h104);
    chk(40'(illegal), 40'h1, "refusal");
    chk(40'(regWe), 40'h0, "register untouched");
    chk(40'(cc.valid), 40'h0, "flags untouched");
    chk(40'(bfcce_mem_model_inst.wrCount), 40'(wc), "memory untouched");
  endtask

  // main sequence
  initial
  begin
    reset       = 1'b1;
    start       = 1'b0;
    opWord      = 16'h0000;
    extWord     = 16'h0000;
    eaAddr      = 32'h0;
    waitCycles  = 4'h0;
    errCount    = 0;
    checkCount  = 0;
    dataRegs    = '0;
    dataRegs[1] = 32'h8F000ACE;
    dataRegs[2] = 32'h80000001;
    dataRegs[3] = 32'hFFFFFFF3;
    dataRegs[4] = 32'h12345678;
    dataRegs[5] = 32'h00000024;
    // same pattern that the memory model loads while reset is high
    for (int i = 0; i < 16; i++)
    begin
      memImg[i] = 8'h96 ^ 8'(i * 29);
    end
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    regOp(BFCCE_OPC_INVERT, 3'h1, 16'h0708, 32'h1C, 8);
    regOp(BFCCE_OPC_ZERO, 3'h2, 16'h0000, 32'h0, 32);
    regOp(BFCCE_OPC_SEXT, 3'h4, 16'h68E5, 32'hFFFFFFF3, 4);
    regOp(BFCCE_OPC_INVERT, 3'h7, 16'h0101, 32'h4, 1);
    $display("register base tests finished");
    // slower answers on each later case
    for (int i = 0; i < 5; i++)
    begin
      waitCycles <= 4'(i * 2);
      memOp(opTab[i % 3], eaTab[i], extTab[i], offTab[i], wTab[i]);
    end
    $display("memory base tests finished");
    for (int i = 0; i < 9; i++)
      badOp(badOpc[i], badEa[i], badExt[i]);
    $display("refusal tests finished");
    finishTest;
  end

  // cut a hang short
  initial
  begin
    #50000;
    errCount++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finishTest;
  end
endmodule // tb_top
